// file: src/pttc_pkg.sv
// Shared constants and types for the event unit control block
`default_nettype none
package pttc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL  = 12'h52c; // Event unit control/status
  localparam logic [11:0] OFF_TNS   = 12'h530; // Target nanoseconds
  localparam logic [11:0] OFF_TSEC  = 12'h534; // Target seconds
  localparam logic [11:0] OFF_INDEX = 12'h540; // Unit index pointers

  // ----------------------------------------------------------------
  // Control/status field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_OUT_SEL   = 8; // Pin output source select
  localparam int unsigned BIT_PIN_IN    = 7; // Pin input monitor
  localparam int unsigned BIT_ROLE      = 6; // Pin role select
  localparam int unsigned BIT_IRQ_EN    = 5; // Stamp unit irq enable
  localparam int unsigned BIT_ACTIVE    = 4; // Fire unit active
  localparam int unsigned BIT_FIRE_EN   = 3; // Fire unit enable
  localparam int unsigned BIT_FIRE_CLR  = 2; // Fire unit soft clear
  localparam int unsigned BIT_STAMP_ON  = 1; // Stamp unit on
  localparam int unsigned BIT_STAMP_CLR = 0; // Stamp unit soft clear

  // ----------------------------------------------------------------
  // Index register fields
  // ----------------------------------------------------------------
  localparam int unsigned IDX_FIRE_LSB  = 0; // Fire pointer bits 1:0
  localparam int unsigned IDX_STAMP_BIT = 8; // Stamp pointer bit

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned NUM_FIRE  = 3;  // Trigger output units
  localparam int unsigned NUM_STAMP = 2;  // Timestamp input units
  localparam int unsigned NS_W      = 30; // Nanoseconds width
  localparam int unsigned SEC_W     = 32; // Seconds width
  localparam int unsigned CNT_W     = 4;  // Event count width
  localparam logic [1:0]  FIRE_IDX_NONE = 2'h3; // Pointer with no unit
  localparam logic [29:0] RST_TNS  = 30'h00000000;
  localparam logic [31:0] RST_TSEC = 32'h00000000;
  localparam logic [3:0]  CNT_MAX  = 4'hf;

  // Fire unit state
  typedef enum logic [0:0] {
    PTTC_FIRE_IDLE  = 1'b0,
    PTTC_FIRE_ARMED = 1'b1
  } pttc_fire_state_t;

endpackage : pttc_pkg
`default_nettype wire

// file: src/pttc_fire_unit.sv
// One trigger output unit: target time, enable, soft clear, fire
`timescale 1ns/1ps
`default_nettype none
module pttc_fire_unit (
  input  wire logic        i_mclk,      // System clock
  input  wire logic        i_arst_n,    // Async reset, active low
  input  wire logic        i_ns_we,     // Write target nanoseconds
  input  wire logic        i_sec_we,    // Write target seconds
  input  wire logic [31:0] i_wdata,     // Bus write data
  input  wire logic        i_en_we,     // Write enable bit
  input  wire logic        i_en_val,    // Enable bit value
  input  wire logic        i_clr_we,    // Write soft clear bit
  input  wire logic        i_clr_val,   // Soft clear bit value
  input  wire logic [31:0] i_now_sec,   // System time seconds
  input  wire logic [29:0] i_now_ns,    // System time nanoseconds
  output logic      [29:0] o_target_ns, // Target nanoseconds
  output logic      [31:0] o_target_sec,// Target seconds
  output logic             o_enable,    // Unit armed
  output logic             o_soft_clr,  // Soft clear held
  output logic             o_fire       // Fire, one cycle
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pttc_pkg::pttc_fire_state_t state_reg;   // Idle or armed
  logic [29:0]                tns_reg;     // Target ns
  logic [31:0]                tsec_reg;    // Target s
  logic                       clr_reg;     // Soft clear bit
  logic                       clr_now;     // Clear in force this cycle
  logic                       reached;     // Time at or past target

  assign clr_now = clr_reg | (i_clr_we & i_clr_val);
  // Seconds first, then nanoseconds
  assign reached = ({i_now_sec, i_now_ns} >= {tsec_reg, tns_reg});
  // Fire only when armed and the target time is reached
  assign o_fire  = (state_reg == pttc_pkg::PTTC_FIRE_ARMED) & ~clr_reg
                   & reached;

  // Soft clear bit storage
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      clr_reg <= 1'b0;
    else if (i_clr_we)
      clr_reg <= i_clr_val; // Held while 1
  end

  // Arm on write 1, self clear on fire, drop on soft clear
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      state_reg <= pttc_pkg::PTTC_FIRE_IDLE;
    else
    begin
      case (state_reg)
        pttc_pkg::PTTC_FIRE_IDLE:
        begin
          if (clr_now)
            state_reg <= pttc_pkg::PTTC_FIRE_IDLE;
          else if (i_en_we && i_en_val)
            state_reg <= pttc_pkg::PTTC_FIRE_ARMED;
        end
        pttc_pkg::PTTC_FIRE_ARMED:
        begin
          if (clr_now)
            state_reg <= pttc_pkg::PTTC_FIRE_IDLE;
          else if (i_en_we)
            state_reg <= i_en_val ? pttc_pkg::PTTC_FIRE_ARMED
                                  : pttc_pkg::PTTC_FIRE_IDLE;
          else if (o_fire)
            state_reg <= pttc_pkg::PTTC_FIRE_IDLE; // Self clear
        end
        default:
          state_reg <= pttc_pkg::PTTC_FIRE_IDLE;
      endcase
    end
  end

  // Target time storage, back to default on soft clear
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tns_reg  <= pttc_pkg::RST_TNS;
      tsec_reg <= pttc_pkg::RST_TSEC;
    end
    else if (clr_now)
    begin
      tns_reg  <= pttc_pkg::RST_TNS;
      tsec_reg <= pttc_pkg::RST_TSEC;
    end
    else
    begin
      if (i_ns_we)
        tns_reg <= i_wdata[29:0];     // Upper bits dropped
      if (i_sec_we)
        tsec_reg <= i_wdata;
    end
  end

  assign o_target_ns  = tns_reg;
  assign o_target_sec = tsec_reg;
  // Active equals armed; no error source in this unit
  assign o_enable     = (state_reg == pttc_pkg::PTTC_FIRE_ARMED);
  assign o_soft_clr   = clr_reg;

endmodule : pttc_fire_unit
`default_nettype wire

// file: src/pttc_top.sv
// Event pin control: pin role, trigger output units, timestamp units
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Output select 1 combinational, 0 flopped
// - Status bit reads live pin input level
// - Role bit: 1 trigger, 0 timestamp input
// - Per stamp unit irq enable, indexed
// - Active flag while selected unit armed
// - Enable arms unit, self clears on fire
// - Fire soft clear returns unit to default
// - Stamp on write 1 clears event count
// - Stamp write 0 clears ready, overflow
// - Stamp soft clear returns unit default
// - Fire fields per unit, 2-bit pointer
// - Stamp fields per unit, 1-bit pointer
// - Per unit 30-bit target nanoseconds
// - Per unit 32-bit target seconds
// - Armed unit fires at target time
// - Stamp irq only when enabled
module pttc_top (
  input  wire logic        i_mclk,      // System clock, 250 MHz
  input  wire logic        i_arst_n,    // Async reset, active low
  input  wire logic [11:0] i_addr,      // Register byte address
  input  wire logic [31:0] i_wdata,     // Write data
  input  wire logic        i_wr,        // Write strobe
  input  wire logic        i_rd,        // Read strobe
  output logic      [31:0] o_rdata,     // Read data, cycle after read
  input  wire logic [31:0] i_now_sec,   // System time seconds
  input  wire logic [29:0] i_now_ns,    // System time nanoseconds
  input  wire logic        i_pin_in,    // Pin input level
  output logic             o_pin_out,   // Pin output level
  output logic             o_pin_oe,    // Pin output enable
  output logic [1:0]       o_stamp_irq, // Per stamp unit interrupt
  output logic [1:0]       o_stamp_rdy  // Per stamp unit ready flag
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_ctrl;   // Write to control/status
  logic wr_tns;    // Write to target ns
  logic wr_tsec;   // Write to target s
  logic wr_index;  // Write to index pointers

  assign wr_ctrl  = i_wr & (i_addr == pttc_pkg::OFF_CTRL);
  assign wr_tns   = i_wr & (i_addr == pttc_pkg::OFF_TNS);
  assign wr_tsec  = i_wr & (i_addr == pttc_pkg::OFF_TSEC);
  assign wr_index = i_wr & (i_addr == pttc_pkg::OFF_INDEX);

  // ----------------------------------------------------------------
  // Index pointers and global pin control
  // ----------------------------------------------------------------
  logic [1:0] fire_idx_reg;  // Selected fire unit
  logic       stamp_idx_reg; // Selected stamp unit
  logic       out_sel_reg;   // Pin output source select
  logic       role_reg;      // Pin role select
  logic       fire_hit;      // Pointer names an existing unit

  // Index register, only pointer bits kept
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      fire_idx_reg  <= 2'h0;
      stamp_idx_reg <= 1'b0;
    end
    else if (wr_index)
    begin
      fire_idx_reg  <= i_wdata[pttc_pkg::IDX_FIRE_LSB +: 2];
      stamp_idx_reg <= i_wdata[pttc_pkg::IDX_STAMP_BIT];
    end
  end

  assign fire_hit = (fire_idx_reg != pttc_pkg::FIRE_IDX_NONE);

  // Global control bits of the control/status word
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      out_sel_reg <= 1'b0;
      role_reg    <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      out_sel_reg <= i_wdata[pttc_pkg::BIT_OUT_SEL];
      role_reg    <= i_wdata[pttc_pkg::BIT_ROLE];
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser and filter
  // ----------------------------------------------------------------
  logic pin_s1_reg;    // First stage, read by second only
  logic pin_s2_reg;    // Second stage
  logic pin_s3_reg;    // Third stage
  logic pin_lvl_reg;   // Accepted pin level
  logic pin_rise;      // Accepted rising edge

  // Three flops, level taken once stages two and three agree
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_s1_reg  <= 1'b0;
      pin_s2_reg  <= 1'b0;
      pin_s3_reg  <= 1'b0;
      pin_lvl_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= i_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (pin_s2_reg == pin_s3_reg)
        pin_lvl_reg <= pin_s3_reg; // Live level for status
    end
  end

  assign pin_rise = (pin_s2_reg == pin_s3_reg) & pin_s3_reg & ~pin_lvl_reg;

  // ----------------------------------------------------------------
  // Trigger output units
  // ----------------------------------------------------------------
  logic [29:0] fire_tns  [pttc_pkg::NUM_FIRE]; // Per unit target ns
  logic [31:0] fire_tsec [pttc_pkg::NUM_FIRE]; // Per unit target s
  logic [2:0]  fire_en;                        // Per unit armed
  logic [2:0]  fire_clr;                       // Per unit soft clear
  logic [2:0]  fire_pulse;                     // Per unit fire
  logic        fire_any;                       // Any unit fires
  logic        pin_out_reg;                    // Flopped pin output

  genvar gi;
  generate
    for (gi = 0; gi < pttc_pkg::NUM_FIRE; gi = gi + 1)
    begin : g_fire
      logic sel; // This unit is the pointed one
      assign sel = (fire_idx_reg == 2'(gi));
      pttc_fire_unit u_fire (
        .i_mclk       (i_mclk),
        .i_arst_n     (i_arst_n),
        .i_ns_we      (wr_tns & sel),
        .i_sec_we     (wr_tsec & sel),
        .i_wdata      (i_wdata),
        .i_en_we      (wr_ctrl & sel),
        .i_en_val     (i_wdata[pttc_pkg::BIT_FIRE_EN]),
        .i_clr_we     (wr_ctrl & sel),
        .i_clr_val    (i_wdata[pttc_pkg::BIT_FIRE_CLR]),
        .i_now_sec    (i_now_sec),
        .i_now_ns     (i_now_ns),
        .o_target_ns  (fire_tns[gi]),
        .o_target_sec (fire_tsec[gi]),
        .o_enable     (fire_en[gi]),
        .o_soft_clr   (fire_clr[gi]),
        .o_fire       (fire_pulse[gi])
      );
    end
  endgenerate

  assign fire_any = |fire_pulse;

  // Flopped copy of the trigger output
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pin_out_reg <= 1'b0;
    else
      pin_out_reg <= fire_any;
  end

  // Source select, driven only in trigger role
  assign o_pin_out = out_sel_reg ? fire_any : pin_out_reg;
  assign o_pin_oe  = role_reg;

  // ----------------------------------------------------------------
  // Timestamp input units
  // ----------------------------------------------------------------
  logic [1:0] stamp_on_reg;   // Per unit enabled
  logic [1:0] stamp_clr_reg;  // Per unit soft clear held
  logic [1:0] stamp_irq_reg;  // Per unit irq enable
  logic [1:0] stamp_rdy_reg;  // Per unit ready flag
  logic [1:0] stamp_ovf_reg;  // Per unit count overflow
  logic [3:0] stamp_cnt_reg [pttc_pkg::NUM_STAMP]; // Event counts
  logic [1:0] stamp_wsel;     // Control write per unit
  logic [1:0] stamp_evt;      // Accepted edge per unit

  // Pointed unit takes the control write
  assign stamp_wsel = {wr_ctrl & stamp_idx_reg, wr_ctrl & ~stamp_idx_reg};
  // Edge counts only when on, not held in clear, timestamp role
  assign stamp_evt  = stamp_on_reg & ~stamp_clr_reg
                      & {2{~role_reg & pin_rise}};

  // Per unit control, events and flags
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stamp_on_reg  <= 2'h0;
      stamp_clr_reg <= 2'h0;
      stamp_irq_reg <= 2'h0;
      stamp_rdy_reg <= 2'h0;
      stamp_ovf_reg <= 2'h0;
      for (int k = 0; k < pttc_pkg::NUM_STAMP; k++)
        stamp_cnt_reg[k] <= 4'h0;
    end
    else
    begin
      for (int k = 0; k < pttc_pkg::NUM_STAMP; k++)
      begin
        if (stamp_wsel[k])
          stamp_clr_reg[k] <= i_wdata[pttc_pkg::BIT_STAMP_CLR];
        if ((stamp_wsel[k] && i_wdata[pttc_pkg::BIT_STAMP_CLR])
            || stamp_clr_reg[k])
        begin
          // Back to defaults while soft clear held
          stamp_on_reg[k]  <= 1'b0;
          stamp_irq_reg[k] <= 1'b0;
          stamp_rdy_reg[k] <= 1'b0;
          stamp_ovf_reg[k] <= 1'b0;
          stamp_cnt_reg[k] <= 4'h0;
        end
        else
        begin
          if (stamp_wsel[k])
          begin
            stamp_on_reg[k]  <= i_wdata[pttc_pkg::BIT_STAMP_ON];
            stamp_irq_reg[k] <= i_wdata[pttc_pkg::BIT_IRQ_EN];
          end
          // Count: write 1 clears, else events advance
          if (stamp_wsel[k] && i_wdata[pttc_pkg::BIT_STAMP_ON])
            stamp_cnt_reg[k] <= 4'h0;
          else if (stamp_evt[k] && stamp_cnt_reg[k] != pttc_pkg::CNT_MAX)
            stamp_cnt_reg[k] <= stamp_cnt_reg[k] + 4'h1;
          // Flags: an edge wins over the write 0 clear
          if (stamp_evt[k])
          begin
            stamp_rdy_reg[k] <= 1'b1;
            if (stamp_cnt_reg[k] == pttc_pkg::CNT_MAX)
              stamp_ovf_reg[k] <= 1'b1;
          end
          else if (stamp_wsel[k] && !i_wdata[pttc_pkg::BIT_STAMP_ON])
          begin
            stamp_rdy_reg[k] <= 1'b0;
            stamp_ovf_reg[k] <= 1'b0;
          end
        end
      end
    end
  end

  // Interrupt only where enabled per unit
  assign o_stamp_irq = stamp_rdy_reg & stamp_irq_reg;
  assign o_stamp_rdy = stamp_rdy_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] ctrl_word;  // Assembled control/status
  logic [31:0] rd_next;    // Next read data

  // Control word from global bits and pointed units
  always_comb
  begin
    ctrl_word = 32'h00000000; // Reserved read zero
    ctrl_word[pttc_pkg::BIT_OUT_SEL]   = out_sel_reg;
    ctrl_word[pttc_pkg::BIT_PIN_IN]    = pin_lvl_reg;
    ctrl_word[pttc_pkg::BIT_ROLE]      = role_reg;
    ctrl_word[pttc_pkg::BIT_IRQ_EN]    = stamp_irq_reg[stamp_idx_reg];
    ctrl_word[pttc_pkg::BIT_STAMP_ON]  = stamp_on_reg[stamp_idx_reg];
    ctrl_word[pttc_pkg::BIT_STAMP_CLR] = stamp_clr_reg[stamp_idx_reg];
    if (fire_hit)
    begin
      ctrl_word[pttc_pkg::BIT_ACTIVE]   = fire_en[fire_idx_reg];
      ctrl_word[pttc_pkg::BIT_FIRE_EN]  = fire_en[fire_idx_reg];
      ctrl_word[pttc_pkg::BIT_FIRE_CLR] = fire_clr[fire_idx_reg];
    end
  end

  // Address mux, unmapped reads zero
  always_comb
  begin
    rd_next = 32'h00000000;
    case (i_addr)
      pttc_pkg::OFF_CTRL:
        rd_next = ctrl_word;
      pttc_pkg::OFF_TNS:
        if (fire_hit)
          rd_next = {2'b00, fire_tns[fire_idx_reg]};
      pttc_pkg::OFF_TSEC:
        if (fire_hit)
          rd_next = fire_tsec[fire_idx_reg];
      pttc_pkg::OFF_INDEX:
      begin
        rd_next[pttc_pkg::IDX_FIRE_LSB +: 2] = fire_idx_reg;
        rd_next[pttc_pkg::IDX_STAMP_BIT]     = stamp_idx_reg;
      end
      default:
        rd_next = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= 32'h00000000;
    else if (i_rd)
      o_rdata <= rd_next;
    else
      o_rdata <= 32'h00000000;
  end

endmodule : pttc_top
`default_nettype wire

// file: verification/pttc_checker.sv
// Port-level concurrent checks for the event pin control block
`timescale 1ns/1ps
`default_nettype none
module pttc_checker (
  input  wire logic        i_mclk,      // System clock
  input  wire logic        i_arst_n,    // Async reset, active low
  input  wire logic [11:0] i_addr,      // Register byte address
  input  wire logic [31:0] i_wdata,     // Write data
  input  wire logic        i_wr,        // Write strobe
  input  wire logic        i_rd,        // Read strobe
  input  wire logic [31:0] o_rdata,     // Read data
  input  wire logic        i_pin_in,    // Pin input level
  input  wire logic        o_pin_oe,    // Pin output enable
  input  wire logic [1:0]  o_stamp_irq, // Stamp interrupts
  input  wire logic [1:0]  o_stamp_rdy  // Stamp ready flags
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic sidx_reg; // Copy of the stamp pointer
  logic mapped;   // Address hits a register
  logic [1:0] clr_m_reg; // Modelled stamp soft clear bits
  logic [1:0] ien_m_reg; // Modelled stamp irq enables

  assign mapped = (i_addr == pttc_pkg::OFF_CTRL) ||
                  (i_addr == pttc_pkg::OFF_TNS) ||
                  (i_addr == pttc_pkg::OFF_TSEC) ||
                  (i_addr == pttc_pkg::OFF_INDEX);

  // Tracks index writes so the pointed stamp unit is known
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      sidx_reg <= 1'b0;
    else if (i_wr && i_addr == pttc_pkg::OFF_INDEX)
      sidx_reg <= i_wdata[pttc_pkg::IDX_STAMP_BIT];
  end

  // Irq enable per stamp unit, zeroed by a soft clear or while it holds
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      clr_m_reg <= 2'h0;
      ien_m_reg <= 2'h0;
    end
    else if (i_wr && i_addr == pttc_pkg::OFF_CTRL)
    begin
      clr_m_reg[sidx_reg] <= i_wdata[pttc_pkg::BIT_STAMP_CLR];
      ien_m_reg[sidx_reg] <= i_wdata[pttc_pkg::BIT_IRQ_EN]
                             & ~i_wdata[pttc_pkg::BIT_STAMP_CLR]
                             & ~clr_m_reg[sidx_reg];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // Pin input left alone long enough to pass the synchroniser
  sequence quiet_pin;
    $stable(i_pin_in)[*6];
  endsequence
  sequence ctrl_rd;
    i_rd && i_addr == pttc_pkg::OFF_CTRL;
  endsequence
  sequence ctrl_wr;
    i_wr && i_addr == pttc_pkg::OFF_CTRL;
  endsequence

  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside read reply");
  AST_CTRL_RSVD: assert property (ctrl_rd |=> o_rdata[31:9] == 23'h0)
    else $error("control reserved bits not zero");
  AST_TNS_RSVD: assert property (
    i_rd && i_addr == pttc_pkg::OFF_TNS |=> o_rdata[31:30] == 2'h0)
    else $error("nanosecond reserved bits not zero");
  AST_UNMAPPED: assert property (i_rd && !mapped |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_PIN_LEVEL: assert property (
    quiet_pin ##0 ctrl_rd |=> o_rdata[7] == $past(i_pin_in))
    else $error("pin level bit wrong");
  AST_OE_ROLE: assert property (
    ctrl_wr ##1 !(i_wr && i_addr == pttc_pkg::OFF_CTRL)
    |=> o_pin_oe == $past(i_wdata[6], 2))
    else $error("output enable does not follow role");
  AST_IRQ_GATE: assert property (
    o_stamp_irq == (o_stamp_rdy & ien_m_reg))
    else $error("stamp interrupt does not follow its enable");
  AST_STAMP_OFF: assert property (
    quiet_pin ##0 (ctrl_wr and !i_wdata[1]) |=> !o_stamp_rdy[sidx_reg])
    else $error("ready not cleared by stamp off");
endmodule : pttc_checker

bind pttc_top pttc_checker u_chk (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_pin_in(i_pin_in), .o_pin_oe(o_pin_oe), .o_stamp_irq(o_stamp_irq),
  .o_stamp_rdy(o_stamp_rdy)
);
`default_nettype wire

// file: verification/ptp_trigger_timestamp_ctrl_tb.sv
// Self-checking bench for the event pin control block
`timescale 1ns/1ps
`default_nettype none
module ptp_trigger_timestamp_ctrl_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;      // 250 MHz clock
  logic        rst_n = 1'b0;    // Reset, active low
  logic [11:0] addr = 12'h0;    // Bus address
  logic [31:0] wdata = 32'h0;   // Bus write data
  logic        wr = 1'b0;       // Write strobe
  logic        rd = 1'b0;       // Read strobe
  logic [31:0] rdata;           // Read data
  logic [31:0] now_sec = 32'h0; // System seconds
  logic [29:0] now_ns = 30'h0;  // System nanoseconds
  logic        pin = 1'b0;      // Pin input
  logic        pin_out;         // Pin output
  logic        pin_oe;          // Pin output enable
  logic [1:0]  irq;             // Stamp interrupts
  logic [1:0]  rdy;             // Stamp ready flags
  int          errors = 0;      // Mismatch count
  int          checked = 0;     // Comparison count

  // One bus access with its write data or expected read value
  typedef struct {logic w; logic [11:0] a; logic [31:0] d;} pttc_row_t;
  localparam int NROW = 22;
  pttc_row_t rows [NROW] = '{
    '{0, 12'h530, 32'h0}, '{0, 12'h534, 32'h0}, '{0, 12'h540, 32'h0},
    '{0, 12'h52c, 32'h0}, '{1, 12'h540, 32'h101}, '{0, 12'h540, 32'h101},
    '{1, 12'h540, 32'hffffffff}, '{0, 12'h540, 32'h103},
    '{1, 12'h540, 32'h0}, '{1, 12'h530, 32'hffffffff},
    '{0, 12'h530, 32'h3fffffff}, '{1, 12'h534, 32'ha5a5a5a5},
    '{0, 12'h534, 32'ha5a5a5a5}, '{1, 12'h540, 32'h1},
    '{0, 12'h530, 32'h0}, '{1, 12'h540, 32'h3}, '{1, 12'h530, 32'h55},
    '{0, 12'h530, 32'h0}, '{1, 12'h600, 32'hffff}, '{0, 12'h600, 32'h0},
    '{1, 12'h52c, 32'hffffff20}, '{0, 12'h52c, 32'h120}};

  pttc_top dut (
    .i_mclk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_now_sec(now_sec),
    .i_now_ns(now_ns), .i_pin_in(pin), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_stamp_irq(irq), .o_stamp_rdy(rdy));

  // Clock generator
  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask : chk

  // Single-cycle write
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask : bus_wr

  // Single-cycle read, data checked in the reply cycle
  task automatic bus_rd(input logic [11:0] a, input logic [31:0] e);
  begin
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  end
  endtask : bus_rd

  // Holds the pin at a level past the synchroniser
  task automatic pin_set(input logic v);
  begin
    @(posedge clk) pin <= v;
    repeat (6) @(posedge clk);
  end
  endtask : pin_set

  task automatic tally_and_finish;
  begin
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask : tally_and_finish

  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Table of register accesses
    for (int i = 0; i < NROW; i++)
      if (rows[i].w) bus_wr(rows[i].a, rows[i].d);
      else bus_rd(rows[i].a, rows[i].d);
    bus_wr(12'h540, 32'h100);
    bus_rd(12'h52c, 32'h100);
    // Fire at target time, combinational output
    bus_wr(12'h540, 32'h0);
    bus_wr(12'h534, 32'h1);
    bus_wr(12'h530, 32'h64);
    @(posedge clk) now_sec <= 32'h1;
    bus_wr(12'h52c, 32'h148);
    bus_rd(12'h52c, 32'h158);
    chk({31'h0, pin_oe}, 32'h1);
    chk({31'h0, pin_out}, 32'h0);
    @(posedge clk) now_ns <= 30'h64;
    #1 chk({31'h0, pin_out}, 32'h1);
    @(posedge clk);
    #1 chk({31'h0, pin_out}, 32'h0);
    bus_rd(12'h52c, 32'h140);
    // Flopped output a cycle later
    @(posedge clk) now_ns <= 30'h0;
    bus_wr(12'h52c, 32'h48);
    @(posedge clk) now_ns <= 30'h64;
    #1 chk({31'h0, pin_out}, 32'h0);
    @(posedge clk);
    #1 chk({31'h0, pin_out}, 32'h1);
    // Fire soft clear drops settings
    bus_wr(12'h52c, 32'h4c);
    bus_rd(12'h52c, 32'h44);
    bus_rd(12'h530, 32'h0);
    bus_wr(12'h52c, 32'h0);
    bus_rd(12'h534, 32'h0);
    // Stamp unit: event, masking, disable
    bus_wr(12'h52c, 32'h22);
    pin_set(1'b1);
    bus_rd(12'h52c, 32'ha2);
    chk({30'h0, rdy}, 32'h1);
    chk({30'h0, irq}, 32'h1);
    bus_wr(12'h52c, 32'h2);
    #1 chk({30'h0, irq}, 32'h0);
    chk({30'h0, rdy}, 32'h1);
    bus_wr(12'h52c, 32'h0);
    #1 chk({30'h0, rdy}, 32'h0);
    pin_set(1'b0);
    // Stamp soft clear
    bus_wr(12'h52c, 32'h22);
    pin_set(1'b1);
    bus_wr(12'h52c, 32'h23);
    #1 chk({30'h0, rdy}, 32'h0);
    bus_rd(12'h52c, 32'h81);
    bus_wr(12'h52c, 32'h0);
    pin_set(1'b0);
    // Reset in mid-run restores defaults
    bus_wr(12'h534, 32'h5a5a5a5a);
    @(posedge clk) rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(12'h534, 32'h0);
    bus_rd(12'h52c, 32'h0);
    tally_and_finish();
  end
endmodule : ptp_trigger_timestamp_ctrl_tb
`default_nettype wire
